/* File: core/ccr_regs.sv */
// Purpose: cpu control and system registers, operand helpers, misaligned
//          access splitter
// Assumes: one clock, synchronous active-low reset, clock enable ce
// Notes:   all outputs registered; bus pieces handshake with bus_done
`timescale 1ns/100ps

// Functional notes
// - 8-bit extended control: trace bit7, mask 2:0
// - trace set raises trace exception per instruction
// - extended control bits 6..3 read as one
// - mask level 0..7 gates interrupt acceptance
// - extended control changed only by control instructions
// - vector base: upper 20 stored, low 12 zero
// - vector base used except reset, address error, indirect
// - vector base resets zero, control loads only
// - short base: upper 24 stored, reset all ones
// - 8-bit absolute address uses short base upper
// - accumulator 64 bit, high keeps 10, sign-extended
// - accumulator changed only by accumulator instructions
// - reset clears trace, sets mask bits to one
// - reset leaves accumulator and other bits alone
// - misaligned word or long split into pieces
// - each piece is its own bus cycle
// - bit select 0..7, byte as two BCD digits
module ccr_regs
  import ccr_pkg::*;
#(
  parameter int ACCUMULATOR_HIGH_HALF_BITS = CCR_ACCUMULATOR_HIGH_HALF_BITS
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire ccr_req_t    req,
  input  wire logic [31:0] mac_addend_hi,
  input  wire logic [31:0] mac_addend_lo,
  input  wire logic        insn_done,
  input  wire logic [2:0]  irq_level,
  input  wire logic        exc_is_reset,
  input  wire logic        exc_is_addr_err,
  input  wire logic        exc_ext_indirect,
  input  wire logic [31:0] exc_offset,
  input  wire logic [7:0]  abs8_disp,
  input  wire logic [7:0]  bit_src,
  input  wire logic [2:0]  bit_num,
  input  wire ccr_mem_t    mem_req,
  input  wire logic        bus_done,
  output logic [31:0]      rdata_q,
  output logic [7:0]       extended_control_reg_q,
  output logic             trace_exc_q,
  output logic             irq_accept_q,
  output logic [31:0]      vector_addr_q,
  output logic [31:0]      abs8_addr_q,
  output logic             bit_value_q,
  output logic [3:0]       bcd_high_q,
  output logic [3:0]       bcd_low_q,
  output logic             mem_ready_q,
  output logic             bus_req_q,
  output logic [31:0]      bus_addr_q,
  output ccr_size_t        bus_size_q,
  output logic             bus_last_q
);

  logic              trace_q;
  logic [2:0]        mask_q;
  logic [31:0]       vbr_q;
  logic [31:0]       sbr_q;
  logic [ACCUMULATOR_HIGH_HALF_BITS-1:0] accumulator_high_half_q;
  logic [31:0]       accumulator_low_half_q;
  logic [7:0]        exr_view;
  logic [7:0]        exr_d;
  logic [31:0]       accumulator_high_half_view;
  logic [63:0]       acc_sum;
  ccr_state_t        state_q;
  logic [31:0]       piece_addr_q;
  logic [1:0]        piece_left_q;
  logic              piece_mid_word_q;
  logic [7:0]        bit_hit;
  logic [31:0]       next_addr;
  ccr_size_t         next_size;
  ccr_size_t         first_size;
  logic [1:0]        first_left;
  logic              first_mid;
  logic              first_last;

  // reserved bits always read back as one
  assign exr_view = {trace_q, 4'hF, mask_q};
  assign accumulator_high_half_view = {{(32-ACCUMULATOR_HIGH_HALF_BITS){accumulator_high_half_q[ACCUMULATOR_HIGH_HALF_BITS-1]}},
                      accumulator_high_half_q};
  assign acc_sum = {accumulator_high_half_view, accumulator_low_half_q} + {mac_addend_hi, mac_addend_lo};

  always_comb begin
    exr_d = exr_view;
    unique case (req.op)
      CCR_OP_LDC:  exr_d = req.wdata[7:0];
      CCR_OP_AND_CONTROL_INSN: exr_d = exr_view & req.wdata[7:0];
      CCR_OP_ORC:  exr_d = exr_view | req.wdata[7:0];
      CCR_OP_XOR_CONTROL_INSN: exr_d = exr_view ^ req.wdata[7:0];
      default:     exr_d = exr_view;
    endcase
  end

  // extended control register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trace_q <= CCR_EXR_RESET[CCR_EXR_TRACE_BIT];
      mask_q  <= CCR_MASK_RESET;
    end else if (ce && req.sel == CCR_SEL_EXR) begin
      trace_q <= exr_d[CCR_EXR_TRACE_BIT];
      mask_q  <= exr_d[CCR_EXR_MASK_MSB:0];
    end
  end

  // vector base, low bits never stored
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vbr_q <= CCR_VBR_RESET;
    end else if (ce && req.op == CCR_OP_LDC && req.sel == CCR_SEL_VBR) begin
      vbr_q <= req.wdata & CCR_VBR_KEEP;
    end
  end

  // short address base, low byte never stored
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sbr_q <= CCR_SBR_RESET;
    end else if (ce && req.op == CCR_OP_LDC && req.sel == CCR_SEL_SBR) begin
      sbr_q <= req.wdata & CCR_SBR_KEEP;
    end
  end

  // accumulator keeps its value through reset
  always_ff @(posedge clock) begin
    if (ce) begin
      unique case (req.op)
        CCR_OP_CLRAC: begin
          accumulator_high_half_q <= '0;
          accumulator_low_half_q <= '0;
        end
        CCR_OP_LDAC: begin
          if (req.sel == CCR_SEL_ACCUMULATOR_HIGH_HALF)
            accumulator_high_half_q <= req.wdata[ACCUMULATOR_HIGH_HALF_BITS-1:0];
          if (req.sel == CCR_SEL_ACCUMULATOR_LOW_HALF)
            accumulator_low_half_q <= req.wdata;
        end
        CCR_OP_MAC: begin
          accumulator_high_half_q <= acc_sum[32 +: ACCUMULATOR_HIGH_HALF_BITS];
          accumulator_low_half_q <= acc_sum[31:0];
        end
        default: begin
          accumulator_high_half_q <= accumulator_high_half_q;
          accumulator_low_half_q <= accumulator_low_half_q;
        end
      endcase
    end
  end

  // read-back for store instructions
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (ce) begin
      if (req.op == CCR_OP_STC) begin
        unique case (req.sel)
          CCR_SEL_EXR: rdata_q <= {24'h000000, exr_view};
          CCR_SEL_VBR: rdata_q <= vbr_q;
          CCR_SEL_SBR: rdata_q <= sbr_q;
          default:     rdata_q <= '0;
        endcase
      end else if (req.op == CCR_OP_STAC) begin
        rdata_q <= (req.sel == CCR_SEL_ACCUMULATOR_HIGH_HALF) ? accumulator_high_half_view : accumulator_low_half_q;
      end
    end
  end

  // mirror of the extended control register for the core
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      extended_control_reg_q <= CCR_EXR_RESET;
    end else if (ce) begin
      extended_control_reg_q <= exr_view;
    end
  end

  // trace request, one pulse per finished instruction
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trace_exc_q <= 1'b0;
    end else if (ce) begin
      trace_exc_q <= trace_q & insn_done;
    end
  end

  // interrupt acceptance against the mask level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_accept_q <= 1'b0;
    end else if (ce) begin
      // level 7 always passes, otherwise level must exceed mask
      irq_accept_q <= (irq_level == 3'h7) ||
                      (irq_level > mask_q);
    end
  end

  // vector address; reset, address error and indirect skip the base
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vector_addr_q <= '0;
    end else if (ce) begin
      if (exc_is_reset || exc_is_addr_err || exc_ext_indirect) begin
        vector_addr_q <= exc_offset;
      end else begin
        vector_addr_q <= vbr_q + exc_offset;
      end
    end
  end

  // short absolute address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      abs8_addr_q <= CCR_SBR_RESET;
    end else if (ce) begin
      abs8_addr_q <= {sbr_q[31:8], abs8_disp};
    end
  end

  // bit operand: one select term per bit, any hit gives the value
  for (genvar g = 0; g < 8; g++) begin : g_bit
    assign bit_hit[g] = bit_src[g] & (bit_num == 3'(g));
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bit_value_q <= 1'b0;
    end else if (ce) begin
      bit_value_q <= |bit_hit;
    end
  end

  // decimal digits of the byte operand
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bcd_high_q <= '0;
      bcd_low_q  <= '0;
    end else if (ce) begin
      bcd_high_q <= bit_src[7:4];
      bcd_low_q  <= bit_src[3:0];
    end
  end

  // shape of the first piece of a new access
  always_comb begin
    first_size = mem_req.size;
    first_left = 2'h0;
    first_mid  = 1'b0;
    first_last = 1'b1;
    if (mem_req.size == CCR_SZ_WORD && mem_req.addr[0]) begin
      first_size = CCR_SZ_BYTE;
      first_left = 2'h1;
      first_last = 1'b0;
    end else if (mem_req.size == CCR_SZ_LONG &&
                 mem_req.addr[1:0] != 2'h0) begin
      first_last = 1'b0;
      if (mem_req.addr[0]) begin
        // byte, word, byte
        first_size = CCR_SZ_BYTE;
        first_left = 2'h2;
        first_mid  = 1'b1;
      end else begin
        first_size = CCR_SZ_WORD;
        first_left = 2'h1;
      end
    end
  end

  // address and size of the piece after the current one
  always_comb begin
    next_addr = piece_addr_q + 32'h00000002;
    next_size = bus_size_q;
    if (bus_size_q == CCR_SZ_BYTE) begin
      next_addr = piece_addr_q + 32'h00000001;
    end
    if (piece_mid_word_q && piece_left_q == 2'h2) begin
      next_size = CCR_SZ_WORD;
    end else if (piece_mid_word_q) begin
      next_size = CCR_SZ_BYTE;
    end
  end

  // misaligned access splitter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q          <= CCR_ST_IDLE;
      mem_ready_q      <= 1'b1;
      bus_req_q        <= 1'b0;
      bus_addr_q       <= '0;
      bus_size_q       <= CCR_SZ_BYTE;
      bus_last_q       <= 1'b0;
      piece_addr_q     <= '0;
      piece_left_q     <= '0;
      piece_mid_word_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        CCR_ST_IDLE: begin
          if (mem_req.valid) begin
            state_q          <= CCR_ST_P0;
            mem_ready_q      <= 1'b0;
            bus_req_q        <= 1'b1;
            bus_addr_q       <= mem_req.addr;
            bus_size_q       <= first_size;
            bus_last_q       <= first_last;
            piece_left_q     <= first_left;
            piece_mid_word_q <= first_mid;
            piece_addr_q     <= mem_req.addr;
          end
        end
        CCR_ST_P0, CCR_ST_P1, CCR_ST_P2: begin
          if (bus_done) begin
            if (piece_left_q == 2'h0) begin
              state_q     <= CCR_ST_IDLE;
              bus_req_q   <= 1'b0;
              bus_last_q  <= 1'b0;
              mem_ready_q <= 1'b1;
            end else begin
              state_q <= (state_q == CCR_ST_P0) ? CCR_ST_P1 : CCR_ST_P2;
              piece_left_q <= piece_left_q - 2'h1;
              bus_last_q   <= (piece_left_q == 2'h1);
              piece_addr_q <= next_addr;
              bus_addr_q   <= next_addr;
              bus_size_q   <= next_size;
            end
          end
        end
        default: state_q <= CCR_ST_IDLE;
      endcase
    end
  end

endmodule

/* File: include/ccr_pkg.sv */
// Purpose: constants and carriers for the cpu control register block
// Assumes: registers are reached only by control-register instructions
// Notes:   selector codes are local encodings of the instruction port
package ccr_pkg;

  localparam int          CCR_EXR_TRACE_BIT = 7;
  localparam int          CCR_EXR_MASK_MSB  = 2;
  localparam logic [7:0]  CCR_EXR_RSVD_MASK = 8'h78;
  localparam logic [7:0]  CCR_EXR_RESET     = 8'h7F;
  localparam logic [2:0]  CCR_MASK_RESET    = 3'h7;
  localparam logic [31:0] CCR_VBR_RESET     = 32'h00000000;
  localparam logic [31:0] CCR_VBR_KEEP      = 32'hFFFFF000;
  localparam logic [31:0] CCR_SBR_RESET     = 32'hFFFFFF00;
  localparam logic [31:0] CCR_SBR_KEEP      = 32'hFFFFFF00;
  localparam int          CCR_ACCUMULATOR_HIGH_HALF_BITS     = 10;

  typedef enum logic [2:0] {
    CCR_SEL_EXR  = 3'h0,
    CCR_SEL_VBR  = 3'h1,
    CCR_SEL_SBR  = 3'h2,
    CCR_SEL_ACCUMULATOR_HIGH_HALF = 3'h3,
    CCR_SEL_ACCUMULATOR_LOW_HALF = 3'h4
  } ccr_sel_t;

  typedef enum logic [3:0] {
    CCR_OP_NONE  = 4'h0,
    CCR_OP_LDC   = 4'h1,
    CCR_OP_STC   = 4'h2,
    CCR_OP_AND_CONTROL_INSN  = 4'h3,
    CCR_OP_ORC   = 4'h4,
    CCR_OP_XOR_CONTROL_INSN  = 4'h5,
    CCR_OP_MAC   = 4'h6,
    CCR_OP_CLRAC = 4'h7,
    CCR_OP_LDAC  = 4'h8,
    CCR_OP_STAC  = 4'h9
  } ccr_op_t;

  typedef struct packed {
    ccr_op_t     op;
    ccr_sel_t    sel;
    logic [31:0] wdata;
  } ccr_req_t;

  typedef enum logic [1:0] {
    CCR_SZ_BYTE = 2'h0,
    CCR_SZ_WORD = 2'h1,
    CCR_SZ_LONG = 2'h2
  } ccr_size_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    ccr_size_t   size;
  } ccr_mem_t;

  typedef enum logic [3:0] {
    CCR_ST_IDLE = 4'b0001,
    CCR_ST_P0   = 4'b0010,
    CCR_ST_P1   = 4'b0100,
    CCR_ST_P2   = 4'b1000
  } ccr_state_t;

endpackage

/* File: verification/ccr_assertions.sv */
// Purpose: port-level checks of the control register block
// Assumes: ce stays high wherever a property looks one cycle ahead
// Notes:   bound to every ccr_regs instance
`timescale 1ns/100ps
module ccr_assertions
  import ccr_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        insn_done,
  input wire logic [31:0] exc_offset,
  input wire logic [7:0]  abs8_disp,
  input wire ccr_mem_t    mem_req,
  input wire logic        bus_done,
  input wire logic [7:0]  extended_control_reg_q,
  input wire logic        trace_exc_q,
  input wire logic [31:0] vector_addr_q,
  input wire logic [31:0] abs8_addr_q,
  input wire logic        mem_ready_q,
  input wire logic        bus_req_q,
  input wire logic [31:0] bus_addr_q,
  input wire ccr_size_t   bus_size_q,
  input wire logic        bus_last_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    mem_ready_q && mem_req.valid && ce;
  endsequence
  sequence s_issue;
    bus_req_q && !mem_ready_q;
  endsequence
  property p_take;
    s_take |=> s_issue;
  endproperty
  a_take: assert property (p_take)
    else $error("request not issued");
  property p_last;
    bus_req_q && bus_last_q && bus_done && ce |=> !bus_req_q ##1 mem_ready_q;
  endproperty
  a_last: assert property (p_last)
    else $error("last piece end");
  property p_hold;
    bus_req_q && !bus_done && ce |=>
      bus_req_q && $stable(bus_addr_q) && $stable(bus_size_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("piece not held");
  property p_odd;
    bus_req_q && bus_addr_q[0] |-> bus_size_q == CCR_SZ_BYTE;
  endproperty
  a_odd: assert property (p_odd)
    else $error("odd piece not byte");
  property p_trace;
    trace_exc_q && $past(ce) |-> $past(insn_done);
  endproperty
  a_trace: assert property (p_trace)
    else $error("stray trace");
  property p_rsvd;
    extended_control_reg_q[6:3] == 4'hF;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits");
  property p_vlow;
    $past(rst_n) && $past(ce) |->
      ((vector_addr_q ^ $past(exc_offset)) & 32'h00000FFF) == 32'h0;
  endproperty
  a_vlow: assert property (p_vlow)
    else $error("vector low bits");
  property p_abs8;
    $past(rst_n) && $past(ce) |-> abs8_addr_q[7:0] == $past(abs8_disp);
  endproperty
  a_abs8: assert property (p_abs8)
    else $error("short address");
endmodule
bind ccr_regs ccr_assertions u_chk (.clock, .rst_n, .ce, .insn_done,
  .exc_offset, .abs8_disp, .mem_req, .bus_done, .extended_control_reg_q,
  .trace_exc_q, .vector_addr_q, .abs8_addr_q, .mem_ready_q, .bus_req_q,
  .bus_addr_q, .bus_size_q, .bus_last_q);

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the control register block
// Assumes: inputs move 1 ns after each rising edge
// Notes:   accumulator is loaded before the mid-run reset
`timescale 1ns/100ps
module tb_top;
  import ccr_pkg::*;
  typedef struct {ccr_op_t o; ccr_sel_t s; logic [31:0] d, e;} ccr_row_t;
  logic        clock = 0, rst_n, ce = 1, insn_done = 0, bus_done = 0;
  logic        exc_is_reset = 0, exc_is_addr_err = 0, exc_ext_indirect = 0;
  logic [2:0]  irq_level = '0, bit_num = '0;
  logic [7:0]  abs8_disp = '0, bit_src = '0, extended_control_reg_q;
  logic [31:0] mac_addend_hi = '0, mac_addend_lo = '0, exc_offset = '0;
  logic [31:0] rdata_q, vector_addr_q, abs8_addr_q, bus_addr_q;
  logic        trace_exc_q, irq_accept_q, bit_value_q, mem_ready_q;
  logic        bus_req_q, bus_last_q;
  logic [3:0]  bcd_high_q, bcd_low_q;
  ccr_req_t    req = '0;
  ccr_mem_t    mem_req = '0;
  ccr_size_t   bus_size_q;
  int          n_mismatch = 0, checked = 0;
  ccr_row_t    rows[11] = '{
    '{CCR_OP_LDC, CCR_SEL_EXR, 32'h0, 32'h78},
    '{CCR_OP_ORC, CCR_SEL_EXR, 32'h5, 32'h7D},
    '{CCR_OP_XOR_CONTROL_INSN, CCR_SEL_EXR, 32'h87, 32'hFA},
    '{CCR_OP_AND_CONTROL_INSN, CCR_SEL_EXR, 32'h2, 32'h7A},
    '{CCR_OP_LDC, CCR_SEL_VBR, 32'hFFFFFFFF, 32'hFFFFF000},
    '{CCR_OP_LDC, CCR_SEL_SBR, 32'h12345678, 32'h12345600},
    '{CCR_OP_LDAC, CCR_SEL_ACCUMULATOR_HIGH_HALF, 32'h155, 32'h155},
    '{CCR_OP_LDAC, CCR_SEL_ACCUMULATOR_HIGH_HALF, 32'hFFFFF3FF, 32'hFFFFFFFF},
    '{CCR_OP_LDAC, CCR_SEL_ACCUMULATOR_LOW_HALF, 32'h89ABCDEF, 32'h89ABCDEF},
    '{CCR_OP_CLRAC, CCR_SEL_ACCUMULATOR_LOW_HALF, 32'h0, 32'h0},
    '{CCR_OP_LDAC, CCR_SEL_ACCUMULATOR_LOW_HALF, 32'h1234, 32'h1234}};
  ccr_regs dut (.*);
  initial forever #50 clock = ~clock;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic op(ccr_op_t o, ccr_sel_t s, logic [31:0] d);
    req = '{o, s, d};
    step();
  endtask
  task automatic rd(ccr_sel_t s, logic [31:0] e);
    op(s >= CCR_SEL_ACCUMULATOR_HIGH_HALF ? CCR_OP_STAC : CCR_OP_STC, s, '0);
    chk(rdata_q, e);
    op(CCR_OP_NONE, s, '0);
  endtask
  task automatic do_reset(bit mid);
    rst_n = 0;
    step(3);
    rst_n = 1;
    chk(extended_control_reg_q, 32'h7F);
    chk(abs8_addr_q, 32'hFFFFFF00);
    chk(mem_ready_q, 1'b1);
    rd(CCR_SEL_VBR, 32'h0);
    if (mid) rd(CCR_SEL_ACCUMULATOR_LOW_HALF, 32'h1234);
  endtask
  task automatic xfer(logic [31:0] a, ccr_size_t z);
    logic [31:0] pa[$];
    ccr_size_t   ps[$];
    pa = '{a};
    ps = '{z};
    if (z == CCR_SZ_WORD && a[0]) begin
      pa = '{a, a + 1};
      ps = '{CCR_SZ_BYTE, CCR_SZ_BYTE};
    end
    if (z == CCR_SZ_LONG && a[1:0] == 2'h2) begin
      pa = '{a, a + 2};
      ps = '{CCR_SZ_WORD, CCR_SZ_WORD};
    end
    if (z == CCR_SZ_LONG && a[0]) begin
      pa = '{a, a + 1, a + 3};
      ps = '{CCR_SZ_BYTE, CCR_SZ_WORD, CCR_SZ_BYTE};
    end
    mem_req = '{1'b1, a, z};
    step();
    mem_req.valid = 1'b0;
    foreach (pa[i]) begin
      if (i > 0) bus_done = 0;
      chk(bus_addr_q, pa[i]);
      chk(bus_size_q, ps[i]);
      chk(bus_last_q, i == pa.size() - 1);
      step();
      bus_done = 1;
      step();
    end
    bus_done = 0;
    chk(bus_req_q, 1'b0);
    step();
  endtask
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial begin
    do_reset(0);
    foreach (rows[i]) begin
      op(rows[i].o, rows[i].s, rows[i].d);
      rd(rows[i].s, rows[i].e);
    end
    exc_offset = 32'h10;
    abs8_disp = 8'hAB;
    bit_src = 8'h5A;
    bit_num = 3'h1;
    irq_level = 3'h3;
    step(3);
    chk(vector_addr_q, 32'hFFFFF010);
    chk(abs8_addr_q, 32'h123456AB);
    chk(irq_accept_q, 1'b1);
    chk(bit_value_q, 1'b1);
    chk({bcd_high_q, bcd_low_q}, 32'h5A);
    for (int i = 0; i < 3; i++) begin
      {exc_is_reset, exc_is_addr_err, exc_ext_indirect} = 3'h4 >> i;
      step(2);
      chk(vector_addr_q, 32'h10);
    end
    {exc_is_reset, exc_is_addr_err, exc_ext_indirect} = 3'h0;
    irq_level = 3'h2;
    step(2);
    chk(irq_accept_q, 1'b0);
    for (int i = 1; i >= 0; i--) begin
      op(CCR_OP_LDC, CCR_SEL_EXR, i ? 32'h80 : 32'h0);
      op(CCR_OP_NONE, CCR_SEL_EXR, '0);
      insn_done = 1;
      step();
      insn_done = 0;
      chk(trace_exc_q, i);
      step();
    end
    xfer(32'h1, CCR_SZ_LONG);
    xfer(32'h3, CCR_SZ_WORD);
    xfer(32'h2, CCR_SZ_LONG);
    xfer(32'h4, CCR_SZ_WORD);
    xfer(32'h8, CCR_SZ_LONG);
    do_reset(1);
    // a load while the clock enable is low must not land
    ce = 0;
    op(CCR_OP_LDC, CCR_SEL_VBR, 32'hABCDE000);
    ce = 1;
    rd(CCR_SEL_VBR, 32'h0);
    final_report();
  end
endmodule
